/* rtl/mhpu_pkg.sv */
// Purpose: Shared constants and carrier types for the host MIDI port block
// Assumes: Single 250 MHz clock, synchronous active-high reset
// Notes: Host I/O and configuration accesses are single-cycle strobes
package mhpu_pkg;

   // Clock and line timing, FIFO depth and data width
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned BAUD_HZ = 31_250;
   localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_HZ;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned DATA_W = 8;

   // Host port offsets from the programmed base
   localparam logic DATA_OFS = 1'h0;
   localparam logic CMD_OFS = 1'h1;

   // Configuration register indices
   localparam logic [7:0] CFG_ACTIVATE = 8'h30;
   localparam logic [7:0] CFG_BASE_HI = 8'h60;
   localparam logic [7:0] CFG_BASE_LO = 8'h61;

   // Reset values
   localparam logic [7:0] BASE_HI_RST = 8'h03;
   localparam logic [7:0] BASE_LO_RST = 8'h30;
   localparam logic ACTIVATE_RST = 1'h0;

   // Legal base address window
   localparam logic [15:0] BASE_MIN = 16'h0100;
   localparam logic [15:0] BASE_MAX = 16'h0FFE;

   // Command codes and acknowledge
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_PASS = 8'h3F;
   localparam logic [7:0] ACK_BYTE = 8'hFE;

   // Status bit positions
   localparam int unsigned ST_RX_EMPTY = 7;
   localparam int unsigned ST_TX_BUSY = 6;

   typedef enum logic {
      MODE_RESET = 1'b0,
      MODE_PASS = 1'b1
   } mhpu_mode_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } mhpu_rx_st_t;

   typedef enum logic {
      TX_IDLE = 1'b0,
      TX_SEND = 1'b1
   } mhpu_tx_st_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mhpu_io_req_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] index;
      logic [7:0] wdata;
   } mhpu_cfg_req_t;

endpackage

/* rtl/mhpu_top.sv */
// Purpose: Host MIDI data/status/command port with full-duplex serial UART
// Assumes: Inputs synchronous to mclk; host strobes last one cycle
// Notes: Functional notes follow
// Functional notes
// - Status bit 7 is low while an acknowledge or received byte awaits the host.
// - Status bit 6 is high while the transmit FIFO is full and cannot take a data byte.
// - Status bits 5 to 0 ignore writes and always read zero.
// - Base plus one takes command writes; reads there return status.
// - Interrupt is high while an acknowledge or received byte is available.
// - Data read drops the interrupt unless more bytes remain queued.
// - Transmit activity and line conditions never touch the interrupt.
// - Activate low disables decode, holds interrupt low, idles the UART.
// - Only codes FFh and 3Fh act, immediately; other codes are ignored.
// - Reset command leaves pass-through, disables UART, flushes receive FIFO.
// - Reset command queues FEh only when not already in pass-through.
// - In reset state serial input bytes and host data writes are dropped.
// - Power-on reset and reset command both enter the reset state.
// - Pass-through command flushes both FIFOs, queues FEh, enables UART.
// - Pass-through moves host and serial bytes unchanged.
// - Pass-through command while in pass-through does nothing.
// - A queued acknowledge is read before any receive FIFO byte.
// - Frames are 31.25 kbaud, start, eight data, no parity, one stop.
// - Data bits go onto and come off the line LSB first.
// - Full duplex with 16-byte transmit and receive FIFOs.
// - Base address from high and low registers, even, 0x0100 to 0x0FFE.
// - Base address itself is the read/write data port.
`timescale 1ns/1ps

module mhpu_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wptr_q, wptr_d, rptr_q, rptr_d;
   logic push, pop;

   assign in_ready = (wptr_q - rptr_q) != (AW + 1)'(DEPTH);
   assign out_valid = wptr_q != rptr_q;
   assign out_data = mem_q[rptr_q[AW-1:0]];
   assign push = in_valid && in_ready && !flush;
   assign pop = out_valid && out_ready && !flush;

   always_comb begin
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      if (flush) begin
         // Flush wins so a stale byte cannot slip past it
         rptr_d = wptr_q;
      end else begin
         if (push) begin
            wptr_d = wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_d = rptr_q + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wptr_q <= '0;
         rptr_q <= '0;
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wptr_q[AW-1:0]] <= in_data;
      end
   end
endmodule

module mhpu_top #(
   parameter int unsigned BIT_CYCLES = mhpu_pkg::BIT_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Host I/O bus
   input wire mhpu_pkg::mhpu_io_req_t io_req,
   output logic [7:0] io_rdata,
   output logic io_hit,
   // Configuration registers
   input wire mhpu_pkg::mhpu_cfg_req_t cfg_req,
   output logic [7:0] cfg_rdata,
   // Interrupt request
   output logic irq,
   // Serial line
   input wire logic serial_music_input,
   output logic serial_music_output
);
   localparam logic [15:0] BIT_M1 = 16'(BIT_CYCLES - 1);
   localparam logic [15:0] HALF_M1 = 16'(BIT_CYCLES / 2 - 1);

   // Configuration state
   logic [7:0] base_hi_q, base_hi_d, base_lo_q, base_lo_d, cfg_rdata_q, cfg_rdata_d;
   logic active_q, active_d;
   logic [15:0] base;
   logic base_ok;

   // Command controller state
   mhpu_pkg::mhpu_mode_t mode_q, mode_d;
   logic ack_q, ack_d;
   logic [7:0] io_rdata_q, io_rdata_d;

   // Decode
   logic hit, data_wr, data_rd, cmd_wr, stat_rd, cmd_reset, cmd_pass, uart_en;
   logic [7:0] status;

   // FIFO wiring
   logic tx_in_ready, tx_out_valid, tx_pop, tx_flush;
   logic [7:0] tx_out_data;
   logic rx_in_valid, rx_in_ready, rx_out_valid, rx_pop, rx_flush;
   logic [7:0] rx_out_data;

   // Receiver state
   mhpu_pkg::mhpu_rx_st_t rx_st_q, rx_st_d;
   logic [15:0] rx_cnt_q, rx_cnt_d;
   logic [2:0] rx_bit_q, rx_bit_d;
   logic [7:0] rx_sh_q, rx_sh_d;

   // Transmitter state
   mhpu_pkg::mhpu_tx_st_t tx_st_q, tx_st_d;
   logic [15:0] tx_cnt_q, tx_cnt_d;
   logic [3:0] tx_bit_q, tx_bit_d;
   logic [9:0] tx_fr_q, tx_fr_d;

   // Address decode
   assign base = {base_hi_q, base_lo_q};
   assign base_ok = (base >= mhpu_pkg::BASE_MIN) && (base <= mhpu_pkg::BASE_MAX);
   assign hit = active_q && base_ok && (io_req.addr[15:1] == base[15:1]);
   assign data_wr = hit && io_req.wr && (io_req.addr[0] == mhpu_pkg::DATA_OFS);
   assign data_rd = hit && io_req.rd && (io_req.addr[0] == mhpu_pkg::DATA_OFS);
   assign cmd_wr = hit && io_req.wr && (io_req.addr[0] == mhpu_pkg::CMD_OFS);
   assign stat_rd = hit && io_req.rd && (io_req.addr[0] == mhpu_pkg::CMD_OFS);
   assign cmd_reset = cmd_wr && (io_req.wdata == mhpu_pkg::CMD_RESET);
   assign cmd_pass = cmd_wr && (io_req.wdata == mhpu_pkg::CMD_PASS);
   assign io_hit = hit && (io_req.rd || io_req.wr);

   // UART sleeps unless active and in pass-through
   assign uart_en = active_q && (mode_q == mhpu_pkg::MODE_PASS);

   always_comb begin
      status = 8'h00;
      status[mhpu_pkg::ST_RX_EMPTY] = !(ack_q || rx_out_valid);
      status[mhpu_pkg::ST_TX_BUSY] = !tx_in_ready;
   end

   // Interrupt tracks only pending read data; transmit side never feeds it
   assign irq = active_q && (ack_q || rx_out_valid);

   // Configuration registers
   always_comb begin
      base_hi_d = base_hi_q;
      base_lo_d = base_lo_q;
      active_d = active_q;
      cfg_rdata_d = cfg_rdata_q;
      if (cfg_req.wr) begin
         case (cfg_req.index)
            mhpu_pkg::CFG_ACTIVATE: active_d = cfg_req.wdata[0];
            mhpu_pkg::CFG_BASE_HI: base_hi_d = cfg_req.wdata;
            mhpu_pkg::CFG_BASE_LO: base_lo_d = {cfg_req.wdata[7:1], 1'b0};
            default: ;
         endcase
      end
      if (cfg_req.rd) begin
         case (cfg_req.index)
            mhpu_pkg::CFG_ACTIVATE: cfg_rdata_d = {7'h00, active_q};
            mhpu_pkg::CFG_BASE_HI: cfg_rdata_d = base_hi_q;
            mhpu_pkg::CFG_BASE_LO: cfg_rdata_d = base_lo_q;
            default: cfg_rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         base_hi_q <= mhpu_pkg::BASE_HI_RST;
         base_lo_q <= mhpu_pkg::BASE_LO_RST;
         active_q <= mhpu_pkg::ACTIVATE_RST;
         cfg_rdata_q <= 8'h00;
      end else begin
         base_hi_q <= base_hi_d;
         base_lo_q <= base_lo_d;
         active_q <= active_d;
         cfg_rdata_q <= cfg_rdata_d;
      end
   end
   assign cfg_rdata = cfg_rdata_q;

   // Command controller and host read path
   assign rx_flush = cmd_reset || (cmd_pass && mode_q == mhpu_pkg::MODE_RESET);
   assign tx_flush = cmd_pass && (mode_q == mhpu_pkg::MODE_RESET);
   assign rx_pop = data_rd && !ack_q;

   always_comb begin
      mode_d = mode_q;
      ack_d = ack_q;
      io_rdata_d = io_rdata_q;
      if (cmd_reset) begin
         mode_d = mhpu_pkg::MODE_RESET;
         ack_d = (mode_q == mhpu_pkg::MODE_RESET);
      end else if (cmd_pass && mode_q == mhpu_pkg::MODE_RESET) begin
         mode_d = mhpu_pkg::MODE_PASS;
         ack_d = 1'b1;
      end
      if (data_rd) begin
         if (ack_q) begin
            io_rdata_d = mhpu_pkg::ACK_BYTE;
            ack_d = 1'b0;
         end else if (rx_out_valid) begin
            io_rdata_d = rx_out_data;
         end else begin
            io_rdata_d = 8'h00;
         end
      end else if (stat_rd) begin
         io_rdata_d = status;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         mode_q <= mhpu_pkg::MODE_RESET;
         ack_q <= 1'b0;
         io_rdata_q <= 8'h00;
      end else begin
         mode_q <= mode_d;
         ack_q <= ack_d;
         io_rdata_q <= io_rdata_d;
      end
   end
   assign io_rdata = io_rdata_q;

   // Transmit FIFO; a full FIFO shows as busy and extra writes fall away
   mhpu_fifo #(
      .WIDTH(mhpu_pkg::DATA_W),
      .DEPTH(mhpu_pkg::FIFO_DEPTH)
   ) u_tx_fifo (
      .mclk(mclk),
      .srst(srst),
      .flush(tx_flush),
      .in_valid(data_wr && mode_q == mhpu_pkg::MODE_PASS),
      .in_ready(tx_in_ready),
      .in_data(io_req.wdata),
      .out_valid(tx_out_valid),
      .out_ready(tx_pop),
      .out_data(tx_out_data)
   );

   // Receive FIFO; the line cannot stall, so a byte meeting a full FIFO is lost
   mhpu_fifo #(
      .WIDTH(mhpu_pkg::DATA_W),
      .DEPTH(mhpu_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .mclk(mclk),
      .srst(srst),
      .flush(rx_flush),
      .in_valid(rx_in_valid),
      .in_ready(rx_in_ready),
      .in_data(rx_sh_q),
      .out_valid(rx_out_valid),
      .out_ready(rx_pop),
      .out_data(rx_out_data)
   );

   // Receiver: mid-bit sampling after a confirmed start bit
   assign rx_in_valid = uart_en && rx_in_ready && (rx_st_q == mhpu_pkg::RX_STOP)
      && (rx_cnt_q == 16'h0000) && serial_music_input;

   always_comb begin
      rx_st_d = rx_st_q;
      rx_cnt_d = rx_cnt_q;
      rx_bit_d = rx_bit_q;
      rx_sh_d = rx_sh_q;
      if (!uart_en) begin
         rx_st_d = mhpu_pkg::RX_IDLE;
      end else begin
         case (rx_st_q)
            mhpu_pkg::RX_IDLE: begin
               if (!serial_music_input) begin
                  rx_st_d = mhpu_pkg::RX_START;
                  rx_cnt_d = HALF_M1;
               end
            end
            mhpu_pkg::RX_START: begin
               if (rx_cnt_q != 16'h0000) begin
                  rx_cnt_d = rx_cnt_q - 16'h0001;
               end else if (!serial_music_input) begin
                  rx_st_d = mhpu_pkg::RX_DATA;
                  rx_cnt_d = BIT_M1;
                  rx_bit_d = 3'h0;
               end else begin
                  // Glitch shorter than half a bit
                  rx_st_d = mhpu_pkg::RX_IDLE;
               end
            end
            mhpu_pkg::RX_DATA: begin
               if (rx_cnt_q != 16'h0000) begin
                  rx_cnt_d = rx_cnt_q - 16'h0001;
               end else begin
                  rx_sh_d = {serial_music_input, rx_sh_q[7:1]};
                  rx_cnt_d = BIT_M1;
                  rx_bit_d = rx_bit_q + 3'h1;
                  if (rx_bit_q == 3'h7) begin
                     rx_st_d = mhpu_pkg::RX_STOP;
                  end
               end
            end
            mhpu_pkg::RX_STOP: begin
               if (rx_cnt_q != 16'h0000) begin
                  rx_cnt_d = rx_cnt_q - 16'h0001;
               end else begin
                  // Bad stop bit drops the byte
                  rx_st_d = mhpu_pkg::RX_IDLE;
               end
            end
            default: rx_st_d = mhpu_pkg::RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_st_q <= mhpu_pkg::RX_IDLE;
         rx_cnt_q <= 16'h0000;
         rx_bit_q <= 3'h0;
         rx_sh_q <= 8'h00;
      end else begin
         rx_st_q <= rx_st_d;
         rx_cnt_q <= rx_cnt_d;
         rx_bit_q <= rx_bit_d;
         rx_sh_q <= rx_sh_d;
      end
   end

   // Transmitter: ten-bit frame shifted out from bit 0, idle level high
   assign tx_pop = uart_en && (tx_st_q == mhpu_pkg::TX_IDLE) && !tx_flush;

   always_comb begin
      tx_st_d = tx_st_q;
      tx_cnt_d = tx_cnt_q;
      tx_bit_d = tx_bit_q;
      tx_fr_d = tx_fr_q;
      if (!uart_en) begin
         // Disabling mid-frame aborts it; the line returns high at once
         tx_st_d = mhpu_pkg::TX_IDLE;
         tx_fr_d = 10'h3FF;
      end else begin
         case (tx_st_q)
            mhpu_pkg::TX_IDLE: begin
               if (tx_pop && tx_out_valid) begin
                  tx_st_d = mhpu_pkg::TX_SEND;
                  tx_fr_d = {1'b1, tx_out_data, 1'b0};
                  tx_cnt_d = BIT_M1;
                  tx_bit_d = 4'h0;
               end
            end
            mhpu_pkg::TX_SEND: begin
               if (tx_cnt_q != 16'h0000) begin
                  tx_cnt_d = tx_cnt_q - 16'h0001;
               end else begin
                  tx_fr_d = {1'b1, tx_fr_q[9:1]};
                  tx_cnt_d = BIT_M1;
                  tx_bit_d = tx_bit_q + 4'h1;
                  if (tx_bit_q == 4'h9) begin
                     tx_st_d = mhpu_pkg::TX_IDLE;
                  end
               end
            end
            default: tx_st_d = mhpu_pkg::TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         tx_st_q <= mhpu_pkg::TX_IDLE;
         tx_cnt_q <= 16'h0000;
         tx_bit_q <= 4'h0;
         tx_fr_q <= 10'h3FF;
      end else begin
         tx_st_q <= tx_st_d;
         tx_cnt_q <= tx_cnt_d;
         tx_bit_q <= tx_bit_d;
         tx_fr_q <= tx_fr_d;
      end
   end
   assign serial_music_output = tx_fr_q[0];

endmodule

/* testbench/mhpu_serial_model.sv */
// Purpose: Serial music device on the far side of the port
// Assumes: Line idles high, bit time is BC clocks
// Notes: Received frames with a low stop bit are dropped
`timescale 1ns/1ps
module mhpu_serial_model #(
   parameter int BC = 16
) (
   // Clock
   input wire logic mclk,
   // Serial line
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] got[$];
   logic [7:0] sh;
   initial line_out = 1'b1;
   // Start, eight data LSB first, stop, one bit time each
   task automatic send(input logic [7:0] b);
      @(negedge mclk) line_out = 1'b0;
      repeat (BC) @(negedge mclk);
      for (int i = 0; i < 8; i++) begin
         line_out = b[i];
         repeat (BC) @(negedge mclk);
      end
      line_out = 1'b1;
      repeat (BC) @(negedge mclk);
   endtask
   // Mid-bit sampling tolerates small rate error
   always begin
      @(negedge line_in);
      repeat (BC / 2) @(negedge mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BC) @(negedge mclk);
         sh[i] = line_in;
      end
      repeat (BC) @(negedge mclk);
      if (line_in) begin
         got.push_back(sh);
      end
   end
endmodule

/* testbench/mhpu_top_assertions.sv */
// Purpose: Port-level checks of the host music port
// Assumes: Single clock, synchronous reset
// Notes: Bound to every mhpu_top instance
`timescale 1ns/1ps
module mhpu_checker #(
   parameter int unsigned BIT_CYCLES = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Host side
   input wire mhpu_pkg::mhpu_io_req_t io_req,
   input wire logic [7:0] io_rdata,
   input wire logic io_hit,
   input wire logic irq,
   // Line side
   input wire logic serial_music_output
);
   default clocking cb @(posedge mclk); endclocking
   logic [15:0] low_q;
   logic [15:0] low_d;
   always_comb begin
      low_d = serial_music_output ? 16'h0000 : low_q + 16'h0001;
   end
   always_ff @(posedge mclk) begin
      low_q <= srst ? 16'h0000 : low_d;
   end
   a_rst_irq_low: assert property (srst |=> !irq)
      else $error("irq high after reset");
   a_rst_line_idle: assert property (srst |=> serial_music_output)
      else $error("line not idle after reset");
   a_rst_rdata_zero: assert property (srst |=> io_rdata == 8'h00)
      else $error("read data not cleared");
   a_status_low_zero: assert property (disable iff (srst)
      io_req.rd && io_hit && io_req.addr[0] |=> io_rdata[5:0] == 6'h00)
      else $error("reserved status bits set");
   a_status_irq_tie: assert property (disable iff (srst)
      io_req.rd && io_hit && io_req.addr[0] |=> io_rdata[7] == !$past(irq))
      else $error("empty flag disagrees with irq");
   a_data_wr_irq: assert property (disable iff (srst)
      io_req.wr && io_hit && !io_req.addr[0] |=> $stable(irq))
      else $error("data write moved irq");
   a_undec_read_hold: assert property (disable iff (srst)
      io_req.rd && !io_hit |=> $stable(io_rdata))
      else $error("undecoded read changed data");
   a_bit_len_whole: assert property (disable iff (srst)
      $rose(serial_music_output) |-> low_q % BIT_CYCLES == 0)
      else $error("low run not whole bit times");
endmodule
bind mhpu_top mhpu_checker #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
   .mclk(mclk),
   .srst(srst),
   .io_req(io_req),
   .io_rdata(io_rdata),
   .io_hit(io_hit),
   .irq(irq),
   .serial_music_output(serial_music_output)
);

/* testbench/midi_host_port_uart_test.sv */
// Purpose: Self-checking bench of the host music port
// Assumes: Base left at its reset value, short bit time
// Notes: Inputs change on the falling edge only
`timescale 1ns/1ps
module midi_host_port_uart_test;
   localparam int BC = 16;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   mhpu_pkg::mhpu_io_req_t io_req = '0;
   mhpu_pkg::mhpu_cfg_req_t cfg_req = '0;
   logic [7:0] io_rdata;
   logic [7:0] cfg_rdata;
   logic io_hit;
   logic irq;
   logic s_in;
   logic s_out;
   logic hit;
   logic [7:0] q;
   logic [7:0] tx[20];
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   always #2 mclk = ~mclk;
   mhpu_top #(.BIT_CYCLES(BC)) dut (
      .mclk(mclk), .srst(srst), .io_req(io_req), .io_rdata(io_rdata), .io_hit(io_hit),
      .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .irq(irq),
      .serial_music_input(s_in), .serial_music_output(s_out)
   );
   mhpu_serial_model #(.BC(BC)) m (.mclk(mclk), .line_in(s_out), .line_out(s_in));
   task automatic complete_run();
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic io(input logic w, input logic a1, input logic [7:0] d);
      @(negedge mclk);
      io_req.rd = !w;
      io_req.wr = w;
      io_req.addr = {15'h0198, a1};
      io_req.wdata = d;
      #1 hit = io_hit;
      @(negedge mclk);
      io_req.rd = 1'b0;
      io_req.wr = 1'b0;
      q = io_rdata;
   endtask
   task automatic rd(input logic a1, input logic [7:0] e);
      io(1'b0, a1, 8'h00);
      chk(q, e);
   endtask
   task automatic cfg(input logic w, input logic [7:0] i, input logic [7:0] d);
      @(negedge mclk);
      cfg_req = {!w, w, i, d};
      @(negedge mclk);
      cfg_req = '0;
      q = cfg_rdata;
   endtask
   task automatic irq_is(input logic e);
      chk({7'h00, irq}, {7'h00, e});
   endtask
   initial begin
      void'($urandom(32'h4c24e30a));
      repeat (10) @(negedge mclk);
      srst = 1'b0;
      cfg(1'b0, 8'h60, 8'h00); chk(q, 8'h03);
      cfg(1'b1, 8'h61, 8'h31);
      cfg(1'b0, 8'h61, 8'h00); chk(q, 8'h30);
      cfg(1'b1, 8'h30, 8'h01);
      rd(1'b1, 8'h80); irq_is(1'b0);
      q = 8'($urandom);
      io(1'b1, 1'b1, (q == 8'hFF || q == 8'h3F) ? 8'h00 : q);
      rd(1'b1, 8'h80);
      io(1'b1, 1'b1, 8'hFF);
      rd(1'b1, 8'h00); irq_is(1'b1);
      cfg(1'b1, 8'h30, 8'h00);
      irq_is(1'b0);
      io(1'b0, 1'b1, 8'h00); chk({7'h00, hit}, 8'h00);
      cfg(1'b1, 8'h30, 8'h01);
      rd(1'b0, 8'hFE); irq_is(1'b0);
      io(1'b1, 1'b0, 8'($urandom));
      io(1'b1, 1'b1, 8'h3F);
      rd(1'b0, 8'hFE);
      io(1'b1, 1'b1, 8'h3F);
      rd(1'b1, 8'h80);
      repeat (12 * BC) @(negedge mclk);
      chk(8'(m.got.size()), 8'h00);
      tx[0] = 8'($urandom);
      tx[1] = 8'($urandom);
      m.send(tx[0]);
      m.send(tx[1]);
      repeat (4) @(negedge mclk);
      irq_is(1'b1);
      rd(1'b0, tx[0]); irq_is(1'b1);
      rd(1'b0, tx[1]); irq_is(1'b0);
      foreach (tx[i]) begin
         tx[i] = 8'($urandom);
         io(1'b1, 1'b0, tx[i]);
      end
      rd(1'b1, 8'hC0);
      repeat (17 * 10 * BC + 40) @(negedge mclk);
      chk(8'(m.got.size()), 8'h11);
      for (int i = 0; i < 17; i++) begin
         chk(m.got[i], tx[i]);
      end
      rd(1'b1, 8'h80);
      m.send(8'($urandom));
      repeat (4) @(negedge mclk);
      io(1'b1, 1'b1, 8'hFF);
      rd(1'b1, 8'h80); irq_is(1'b0);
      // No later flush can hide bytes taken while in the reset state
      m.send(8'($urandom));
      repeat (4) @(negedge mclk);
      for (int i = 0; i < 16; i++) begin
         io(1'b1, 1'b0, 8'($urandom));
      end
      rd(1'b1, 8'h80); irq_is(1'b0);
      complete_run();
   end
endmodule
